// ===== src/uart_rx_map.svh
// register offsets, field positions, reset values and timing constants of the receiver
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH
`define REG_TX_CTRL     8'h00
`define REG_RX_CTRL     8'h04
`define REG_BAUD_CTRL   8'h08
`define REG_RX_DATA     8'h0C
`define REG_DIV_LOW     8'h10
`define REG_DIV_HIGH    8'h14
`define REG_INT_EN      8'h18
`define TXC_CLK_SRC     7
`define TXC_NINE        6
`define TXC_TX_EN       5
`define TXC_SYNC        4
`define TXC_BREAK       3
`define TXC_HIGH_BAUD   2
`define TXC_NINTH       0
`define RXC_PORT_EN     7
`define RXC_NINE        6
`define RXC_SINGLE      5
`define RXC_CONT        4
`define RXC_ADDR_DET    3
`define BC_CLK_POL      4
`define BC_WIDE         3
`define BC_WAKE         1
`define BC_AB_EN        0
`define TX_CTRL_WMASK   8'hFD
`define RX_CTRL_WMASK   8'hF8
`define BAUD_CTRL_WMASK 8'h1B
`define CTRL_RESET      8'h00
`define MULT_SLOW       7'h40
`define MULT_MID        7'h10
`define MULT_FAST       7'h04
`define OVERSAMPLE_LOG2 4
`endif

// ===== src/uart_rx_pkg.sv
// types shared by the asynchronous receiver
package uart_rx_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_t;
  typedef logic [8:0] rx_char_t;
endpackage

// ===== src/uart_async_receiver_ctrl.sv
// asynchronous serial receiver with control and status registers on apb
//
// Operation
// - sync mode bit picks asynchronous (0) or synchronous (1); receiver needs 0
// - port enable hands pins to port; clearing it holds the port in reset
// - nine-bit select shifts nine data bits, otherwise eight
// - continuous receive enable switches the asynchronous receiver on and off
// - character into buffer raises flag; interrupt only with interrupt enable
// - nine-bit address detect loads only characters whose ninth bit is one
// - overrun flag sets on overrun, clears when continuous receive is cleared
// - framing flag follows head character, updates on read and next arrival
// - ninth bit of head character shown unchanged, no parity logic
// - single receive clears itself after one character in synchronous master mode, continuous overrides
// - clock source bit picks synchronous master or slave
// - transmit control holds nine-bit select, enable and ninth data bit
// - break request goes with next transmission, cleared when break completes
// - high baud select picks fast or slow asynchronous timing
// - transmit shift empty reads one when empty, resets to one
// - idle flag is one while idle, zero from start bit to end of character
// - clock polarity inverts async transmit data or picks sync clock edge
// - wide divider selects sixteen-bit divisor, otherwise eight-bit
// - wake-up waits for falling edge, sets flag, then clears itself
// - auto-baud enable starts detection, self clears; overflow flag reported
// - two-entry fifo with per-entry framing status, data read pops head
// - half-bit start check aborts silently; later bits a full bit apart
// - third character with two unread sets overrun, blocks further reception
// - baud period is divisor plus one times 64, 16 or 4; write resets timer
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_map.svh"

module uart_async_receiver_ctrl
  import uart_rx_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial line
  input  wire logic        RX_PIN,
  output logic             PORT_ENABLE,
  // receive events
  output logic             RX_CHAR_FLAG,
  output logic             RX_INT_REQ,
  output logic             RX_IDLE,
  // controls to transmit, synchronous and auto-baud logic
  output logic             SYNC_MODE,
  output logic             CLK_SRC_MASTER,
  output logic             TX_NINE_BIT,
  output logic             TX_ENABLE,
  output logic             TX_NINTH_BIT,
  output logic             BREAK_REQ,
  output logic             HIGH_BAUD,
  output logic             CLK_POLARITY,
  output logic             WIDE_DIVIDER,
  output logic             SINGLE_RX_ENABLE,
  output logic             CONT_RX_ENABLE,
  output logic             AUTOBAUD_START,
  output logic             BAUD_TICK,
  // status from transmit, synchronous and auto-baud logic
  input  wire logic        TX_SHIFT_EMPTY,
  input  wire logic        BREAK_DONE,
  input  wire logic        SYNC_RX_DONE,
  input  wire logic        AUTOBAUD_DONE,
  input  wire logic        AUTOBAUD_OVF
);

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [6:0] mult_sel(input logic sync, input logic wide, input logic high);
    if (sync || (wide && high)) begin
      mult_sel = `MULT_FAST;
    end else if (wide || high) begin
      mult_sel = `MULT_MID;
    end else begin
      mult_sel = `MULT_SLOW;
    end
  endfunction

  logic [7:0]  tx_ctrl_r;
  logic [7:0]  rx_ctrl_r;
  logic [7:0]  baud_ctrl_r;
  logic [7:0]  div_low_r;
  logic [7:0]  div_high_r;
  logic        int_en_r;
  logic        tx_empty_r;
  logic        ab_ovf_r;
  logic [31:0] prdata_r;
  logic        pop_ok_r;
  logic        rx_meta_r;
  logic        rx_sync_r;
  logic        rx_prev_r;
  logic [15:0] div_cnt_r;
  logic        tick_r;
  rx_state_t   state_r;
  logic [6:0]  phase_r;
  logic [3:0]  bit_cnt_r;
  logic        samp_a_r;
  logic        samp_b_r;
  rx_char_t    shift_r;
  rx_char_t    fifo_data_r [2];
  logic        fifo_framing_error_flag_r [2];
  logic        head_r;
  logic [1:0]  count_r;
  logic        overrun_error_flag_r;
  logic        wake_flag_r;

  logic        serial_port_enable;
  logic        sync_mode;
  logic        rx9;
  logic        continuous_receive_enable;
  logic        rx_en;
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [7:0]  rd_mux;
  logic [15:0] div_n;
  logic [6:0]  mult;
  logic [6:0]  step;
  logic [6:0]  half;
  logic        fall;
  logic        vote;
  logic        sample_pt;
  logic        char_done;
  logic        accept;
  logic        push;
  logic        pop;
  logic        ovr_set;
  logic        wake_set;
  logic        head_framing_error_flag;
  rx_char_t    head_char;
  logic        tail;

  assign serial_port_enable      = rx_ctrl_r[`RXC_PORT_EN];
  assign sync_mode = tx_ctrl_r[`TXC_SYNC];
  assign rx9       = rx_ctrl_r[`RXC_NINE];
  assign continuous_receive_enable      = rx_ctrl_r[`RXC_CONT];
  assign rx_en     = serial_port_enable & ~sync_mode & continuous_receive_enable;
  assign setup     = PSEL & ~PENABLE;
  assign access    = PSEL & PENABLE;
  assign wr        = access & PWRITE;
  assign head_char = (count_r != 2'h0) ? fifo_data_r[head_r] : 9'h000;
  assign head_framing_error_flag = (count_r != 2'h0) ? fifo_framing_error_flag_r[head_r] : 1'b0;
  assign tail      = head_r ^ count_r[0];

  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    if (PADDR == `REG_TX_CTRL) begin
      rd_mux = {tx_ctrl_r[7:2], tx_empty_r, tx_ctrl_r[0]};
    end else if (PADDR == `REG_RX_CTRL) begin
      rd_mux = {rx_ctrl_r[7:3], head_framing_error_flag, overrun_error_flag_r, head_char[8]};
    end else if (PADDR == `REG_BAUD_CTRL) begin
      rd_mux = {ab_ovf_r, (state_r == ST_IDLE), 1'b0, baud_ctrl_r[4:3], 1'b0, baud_ctrl_r[1:0]};
    end else if (PADDR == `REG_RX_DATA) begin
      rd_mux = head_char[7:0];
    end else if (PADDR == `REG_DIV_LOW) begin
      rd_mux = div_low_r;
    end else if (PADDR == `REG_DIV_HIGH) begin
      rd_mux = div_high_r;
    end else if (PADDR == `REG_INT_EN) begin
      rd_mux = {7'h00, int_en_r};
    end else begin
      mapped = 1'b0;
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign PRDATA  = prdata_r;

  // read data is fixed at setup so the status seen matches the character popped
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      prdata_r <= 32'h00000000;
    end else if (setup && !PWRITE) begin
      prdata_r <= {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pop_ok_r <= 1'b0;
    end else if (setup) begin
      pop_ok_r <= ~PWRITE & (PADDR == `REG_RX_DATA) & (count_r != 2'h0);
    end else if (access) begin
      pop_ok_r <= 1'b0;
    end
  end

  assign pop = access & ~PWRITE & pop_ok_r & (count_r != 2'h0);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_ctrl_r <= `CTRL_RESET;
    end else if (wr && PADDR == `REG_TX_CTRL) begin
      tx_ctrl_r <= PWDATA[7:0] & `TX_CTRL_WMASK;
    end else if (BREAK_DONE) begin
      tx_ctrl_r[`TXC_BREAK] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_ctrl_r <= `CTRL_RESET;
    end else if (wr && PADDR == `REG_RX_CTRL) begin
      rx_ctrl_r <= PWDATA[7:0] & `RX_CTRL_WMASK;
    end else if (sync_mode && tx_ctrl_r[`TXC_CLK_SRC] && !continuous_receive_enable && SYNC_RX_DONE) begin
      rx_ctrl_r[`RXC_SINGLE] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      baud_ctrl_r <= `CTRL_RESET;
    end else if (wr && PADDR == `REG_BAUD_CTRL) begin
      baud_ctrl_r <= PWDATA[7:0] & `BAUD_CTRL_WMASK;
    end else begin
      if (wake_set) begin
        baud_ctrl_r[`BC_WAKE] <= 1'b0;
      end
      if (AUTOBAUD_DONE) begin
        baud_ctrl_r[`BC_AB_EN] <= 1'b0;
      end
    end
  end

  // overflow report is sticky until software starts a new detection
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ab_ovf_r <= 1'b0;
    end else if (AUTOBAUD_OVF) begin
      ab_ovf_r <= 1'b1;
    end else if (wr && PADDR == `REG_BAUD_CTRL && PWDATA[`BC_AB_EN]) begin
      ab_ovf_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_low_r  <= `CTRL_RESET;
      div_high_r <= `CTRL_RESET;
      int_en_r   <= 1'b0;
    end else if (wr) begin
      if (PADDR == `REG_DIV_LOW) begin
        div_low_r <= PWDATA[7:0];
      end
      if (PADDR == `REG_DIV_HIGH) begin
        div_high_r <= PWDATA[7:0];
      end
      if (PADDR == `REG_INT_EN) begin
        int_en_r <= PWDATA[0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_empty_r <= 1'b1;
    end else begin
      tx_empty_r <= TX_SHIFT_EMPTY;
    end
  end

  // line synchroniser, idle high
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= RX_PIN;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  assign fall = rx_prev_r & ~rx_sync_r;

  // baud timer; restarted on a divisor write and on a start edge to align sampling
  assign div_n = baud_ctrl_r[`BC_WIDE] ? {div_high_r, div_low_r} : {8'h00, div_low_r};
  assign mult  = mult_sel(sync_mode, baud_ctrl_r[`BC_WIDE], tx_ctrl_r[`TXC_HIGH_BAUD]);
  assign step  = (mult == `MULT_FAST) ? 7'h01 : (mult >> `OVERSAMPLE_LOG2);
  assign half  = mult >> 1;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end else if (wr && (PADDR == `REG_DIV_LOW || PADDR == `REG_DIV_HIGH)) begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end else if (state_r == ST_IDLE && fall) begin
      // tick at once so phase zero is the first start-bit clock; at four clocks a bit
      // a lost tick would push the centre samples into the next bit
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b1;
    end else if (div_cnt_r >= div_n) begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      tick_r    <= 1'b0;
    end
  end

  assign BAUD_TICK = tick_r;

  assign sample_pt = tick_r & (phase_r == half + step - 7'h01);
  assign vote      = maj3(samp_a_r, samp_b_r, rx_sync_r);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      samp_a_r <= 1'b1;
      samp_b_r <= 1'b1;
    end else if (tick_r) begin
      if (phase_r == half - step - 7'h01) begin
        samp_a_r <= rx_sync_r;
      end
      if (phase_r == half - 7'h01) begin
        samp_b_r <= rx_sync_r;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else if (!rx_en) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (fall && !baud_ctrl_r[`BC_WAKE]) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (sample_pt) begin
            state_r <= vote ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (sample_pt && bit_cnt_r == (rx9 ? 4'h8 : 4'h7)) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (sample_pt) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // phase counts baud ticks within one bit; state changes at the sample point
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_r <= 7'h00;
    end else if (state_r == ST_IDLE) begin
      phase_r <= 7'h00;
    end else if (tick_r) begin
      phase_r <= (phase_r >= mult - 7'h01) ? 7'h00 : phase_r + 7'h01;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 9'h000;
    end else if (state_r == ST_DATA) begin
      if (sample_pt) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        shift_r   <= {vote, shift_r[8:1]};
      end
    end else begin
      bit_cnt_r <= 4'h0;
    end
  end

  assign char_done = rx_en & (state_r == ST_STOP) & sample_pt;
  assign accept    = ~rx9 | ~rx_ctrl_r[`RXC_ADDR_DET] | shift_r[8];
  assign push      = char_done & accept & ~overrun_error_flag_r & ((count_r != 2'h2) | pop);
  assign ovr_set   = char_done & accept & ~overrun_error_flag_r & (count_r == 2'h2) & ~pop;

  // eight-bit characters land in the upper eight shift positions
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fifo_data_r[0] <= 9'h000;
      fifo_data_r[1] <= 9'h000;
      fifo_framing_error_flag_r[0] <= 1'b0;
      fifo_framing_error_flag_r[1] <= 1'b0;
    end else if (push) begin
      fifo_data_r[tail] <= rx9 ? shift_r : {1'b0, shift_r[8:1]};
      fifo_framing_error_flag_r[tail] <= ~vote;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      head_r  <= 1'b0;
      count_r <= 2'h0;
    end else if (!serial_port_enable) begin
      head_r  <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (pop) begin
        head_r <= ~head_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      overrun_error_flag_r <= 1'b0;
    end else if (!serial_port_enable || !continuous_receive_enable) begin
      overrun_error_flag_r <= 1'b0;
    end else if (ovr_set) begin
      overrun_error_flag_r <= 1'b1;
    end
  end

  assign wake_set = serial_port_enable & ~sync_mode & baud_ctrl_r[`BC_WAKE] & (state_r == ST_IDLE) & fall;

  // a wake edge in the same cycle as a data read still leaves the flag set
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wake_flag_r <= 1'b0;
    end else if (!serial_port_enable) begin
      wake_flag_r <= 1'b0;
    end else if (wake_set) begin
      wake_flag_r <= 1'b1;
    end else if (access && !PWRITE && PADDR == `REG_RX_DATA) begin
      wake_flag_r <= 1'b0;
    end
  end

  assign RX_CHAR_FLAG     = (count_r != 2'h0) | wake_flag_r;
  assign RX_INT_REQ       = RX_CHAR_FLAG & int_en_r;
  assign RX_IDLE          = (state_r == ST_IDLE);
  assign PORT_ENABLE      = serial_port_enable;
  assign SYNC_MODE        = sync_mode;
  assign CLK_SRC_MASTER   = tx_ctrl_r[`TXC_CLK_SRC];
  assign TX_NINE_BIT      = tx_ctrl_r[`TXC_NINE];
  assign TX_ENABLE        = tx_ctrl_r[`TXC_TX_EN];
  assign TX_NINTH_BIT     = tx_ctrl_r[`TXC_NINTH];
  assign BREAK_REQ        = tx_ctrl_r[`TXC_BREAK];
  assign HIGH_BAUD        = tx_ctrl_r[`TXC_HIGH_BAUD];
  assign CLK_POLARITY     = baud_ctrl_r[`BC_CLK_POL];
  assign WIDE_DIVIDER     = baud_ctrl_r[`BC_WIDE];
  assign SINGLE_RX_ENABLE = rx_ctrl_r[`RXC_SINGLE];
  assign CONT_RX_ENABLE   = continuous_receive_enable;
  assign AUTOBAUD_START   = baud_ctrl_r[`BC_AB_EN] & ~sync_mode;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  start_abort_a: assert property ((state_r == ST_START) && sample_pt && rx_en && vote
    |=> state_r == ST_IDLE) else $error("false start not dropped");
  pop_count_a: assert property (pop && !push |=> count_r == $past(count_r) - 2'h1)
    else $error("read did not pop fifo");
  overrun_set_a: assert property ($rose(overrun_error_flag_r) |-> $past(count_r) == 2'h2 && $past(char_done))
    else $error("overrun without full fifo");
  overrun_clr_a: assert property (serial_port_enable && !continuous_receive_enable |=> !overrun_error_flag_r)
    else $error("overrun not cleared");
  addr_filter_a: assert property (char_done && rx9 && rx_ctrl_r[`RXC_ADDR_DET] && !shift_r[8]
    |-> !push) else $error("data character passed address filter");
  push_flag_a: assert property (push |=> RX_CHAR_FLAG)
    else $error("flag not raised on character");
  first_framing_error_flag_a: assert property (push && count_r == 2'h0 && serial_port_enable |=> head_framing_error_flag == $past(!vote))
    else $error("framing status wrong");
  idle_drop_a: assert property (state_r == ST_IDLE && rx_en && fall && !baud_ctrl_r[`BC_WAKE]
    |=> !RX_IDLE) else $error("idle flag stuck high");
  wake_clear_a: assert property ($rose(wake_flag_r) |-> !baud_ctrl_r[`BC_WAKE] && RX_CHAR_FLAG)
    else $error("wake-up did not clear");
  div_reset_a: assert property (wr && PADDR == `REG_DIV_LOW |=> div_cnt_r == 16'h0000 && !tick_r)
    else $error("divisor write left timer running");
  port_reset_a: assert property (!serial_port_enable |=> count_r == 2'h0 && state_r == ST_IDLE)
    else $error("port not held in reset");

endmodule
`default_nettype wire

// ===== verif/serial_tx_model.sv
// remote asynchronous transmitter that drives the receive line
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model (
  // clock
  input  wire logic       clk,
  // frame request, pulsed high for one clock by the bench
  input  wire logic       go,
  input  wire logic [8:0] data,
  input  wire logic       nine,
  input  wire logic       stop_bit,
  input  wire logic [7:0] bit_clks,
  // line
  output var  logic       line,
  output var  logic       busy
);
  task automatic hold(input logic v);
    line <= v;
    repeat (bit_clks) @(posedge clk);
  endtask
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        hold(1'b0);
        for (int i = 0; i < (nine ? 9 : 8); i++)
          hold(data[i]);
        hold(stop_bit);
        // idle level between frames is high, never a stale bit
        line <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/uart_async_receiver_ctrl_bench.sv
// self-checking bench for the asynchronous receiver and its registers
`timescale 1ns/10ps
`default_nettype none
module uart_async_receiver_ctrl_bench;
  typedef struct packed {logic nine; logic [8:0] d; logic stp; logic [7:0] ctl;} row_t;
  logic        CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_PIN, PORT_ENABLE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        RX_CHAR_FLAG, RX_INT_REQ, RX_IDLE, HIGH_BAUD, WIDE_DIVIDER, BREAK_REQ;
  logic        AUTOBAUD_START, TX_SHIFT_EMPTY, BREAK_DONE, SYNC_RX_DONE, AUTOBAUD_DONE;
  logic        AUTOBAUD_OVF, slverr, tx_go, tx_nine, tx_stop, tx_busy;
  logic        SYNC_MODE, CLK_SRC_MASTER, TX_NINE_BIT, TX_ENABLE, TX_NINTH_BIT, CLK_POLARITY;
  logic        SINGLE_RX_ENABLE, CONT_RX_ENABLE, BAUD_TICK;
  logic [8:0]  tx_data;
  logic [7:0]  tx_bclk;
  int          fail_count, total_checks;
  // rows: nine-bit mode, character, stop level, expected receive status
  row_t rows [6] = '{'{1'b0, 9'h055, 1'b1, 8'h90}, '{1'b0, 9'h0A3, 1'b0, 8'h94},
                     '{1'b1, 9'h1C5, 1'b1, 8'hD1}, '{1'b1, 9'h03A, 1'b1, 8'hD0},
                     '{1'b0, 9'h000, 1'b1, 8'h90}, '{1'b1, 9'h1FF, 1'b0, 8'hD5}};

  uart_async_receiver_ctrl dut (
    .CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .RX_PIN, .PORT_ENABLE, .RX_CHAR_FLAG, .RX_INT_REQ, .RX_IDLE, .SYNC_MODE,
    .CLK_SRC_MASTER, .TX_NINE_BIT, .TX_ENABLE, .TX_NINTH_BIT, .BREAK_REQ,
    .HIGH_BAUD, .CLK_POLARITY, .WIDE_DIVIDER, .SINGLE_RX_ENABLE, .CONT_RX_ENABLE,
    .AUTOBAUD_START, .BAUD_TICK, .TX_SHIFT_EMPTY, .BREAK_DONE, .SYNC_RX_DONE,
    .AUTOBAUD_DONE, .AUTOBAUD_OVF);
  serial_tx_model far (.clk(CORE_CLK), .go(tx_go), .data(tx_data), .nine(tx_nine),
    .stop_bit(tx_stop), .bit_clks(tx_bclk), .line(RX_PIN), .busy(tx_busy));

  always #12.5 CORE_CLK = ~CORE_CLK;

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; an idle edge first so psel is never set twice in one step,
  // and one after release so outputs changed by the access have settled for checks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CORE_CLK);
      if (PREADY === 1'b1)
        break;
    end
    if (n == 50) begin
      fail_count++;
      finish_test();
    end
    rd = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // one frame; idle flag is looked at ten clocks in, then wait for the line to settle
  task automatic send(input logic [8:0] d, input logic n9, input logic s, input logic [7:0] bc,
                      input logic exp_idle);
    int n;
    @(posedge CORE_CLK);
    tx_data <= d;
    tx_nine <= n9;
    tx_stop <= s;
    tx_bclk <= bc;
    tx_go <= 1'b1;
    @(posedge CORE_CLK);
    tx_go <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    chk(32'(RX_IDLE), 32'(exp_idle));
    for (n = 0; n < 400 && (tx_busy === 1'b1 || RX_IDLE !== 1'b1); n++)
      @(posedge CORE_CLK);
    if (n == 400) begin
      fail_count++;
      finish_test();
    end
    @(posedge CORE_CLK);
  endtask

  initial begin
    CORE_CLK = 1'b0;
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {BREAK_DONE, SYNC_RX_DONE, AUTOBAUD_DONE, AUTOBAUD_OVF, tx_go, tx_nine, tx_stop} = '0;
    TX_SHIFT_EMPTY = 1'b1;
    tx_data = 9'h000;
    tx_bclk = 8'h04;
    fail_count = 0;
    total_checks = 0;
    repeat (16) @(posedge CORE_CLK);
    RST <= 1'b0;
    rdchk(8'h00, 32'h02);
    rdchk(8'h04, 32'h00);
    rdchk(8'h08, 32'h40);
    rdchk(8'h1C, 32'h00);
    chk(32'(slverr), 32'h1);
    // reserved and read-only bits must not take the write; wide divider with high baud
    apb(1'b1, 8'h08, 32'hEC);
    rdchk(8'h08, 32'h48);
    chk(32'(WIDE_DIVIDER), 32'h1);
    apb(1'b1, 8'h00, 32'h2E);
    TX_SHIFT_EMPTY <= 1'b0;
    rdchk(8'h00, 32'h2C);
    chk(32'(HIGH_BAUD), 32'h1);
    chk(32'(BREAK_REQ), 32'h1);
    TX_SHIFT_EMPTY <= 1'b1;
    BREAK_DONE <= 1'b1;
    @(posedge CORE_CLK);
    BREAK_DONE <= 1'b0;
    rdchk(8'h00, 32'h26);
    apb(1'b1, 8'h00, 32'h25);
    rdchk(8'h00, 32'h27);
    chk(32'(TX_ENABLE), 32'h1);
    chk(32'(TX_NINTH_BIT), 32'h1);
    AUTOBAUD_OVF <= 1'b1;
    @(posedge CORE_CLK);
    AUTOBAUD_OVF <= 1'b0;
    rdchk(8'h08, 32'hC8);
    apb(1'b1, 8'h08, 32'h09);
    rdchk(8'h08, 32'h49);
    chk(32'(AUTOBAUD_START), 32'h1);
    AUTOBAUD_DONE <= 1'b1;
    @(posedge CORE_CLK);
    AUTOBAUD_DONE <= 1'b0;
    rdchk(8'h08, 32'h48);
    apb(1'b1, 8'h10, 32'h00);
    apb(1'b1, 8'h18, 32'h01);
    foreach (rows[i]) begin
      apb(1'b1, 8'h04, {24'h0, 1'b1, rows[i].nine, 6'h10});
      send(rows[i].d, rows[i].nine, rows[i].stp, 8'h04, 1'b0);
      chk(32'(PORT_ENABLE), 32'h1);
      chk(32'(CONT_RX_ENABLE), 32'h1);
      chk(32'(RX_CHAR_FLAG), 32'h1);
      chk(32'(RX_INT_REQ), 32'h1);
      rdchk(8'h04, 32'(rows[i].ctl));
      rdchk(8'h0C, 32'(rows[i].d[7:0]));
      chk(32'(RX_CHAR_FLAG), 32'h0);
    end
    // a one-clock low pulse fails the half-bit start check
    send(9'h0FF, 1'b0, 1'b1, 8'h01, 1'b1);
    chk(32'(RX_CHAR_FLAG), 32'h0);
    apb(1'b1, 8'h08, 32'h0A);
    send(9'h0FF, 1'b0, 1'b1, 8'h01, 1'b1);
    chk(32'(RX_CHAR_FLAG), 32'h1);
    rdchk(8'h08, 32'h48);
    rdchk(8'h0C, 32'h00);
    chk(32'(RX_CHAR_FLAG), 32'h0);
    apb(1'b1, 8'h04, 32'h90);
    send(9'h011, 1'b0, 1'b1, 8'h04, 1'b0);
    send(9'h022, 1'b0, 1'b1, 8'h04, 1'b0);
    send(9'h033, 1'b0, 1'b1, 8'h04, 1'b0);
    rdchk(8'h04, 32'h92);
    apb(1'b1, 8'h18, 32'h00);
    rdchk(8'h0C, 32'h11);
    chk(32'(RX_INT_REQ), 32'h0);
    rdchk(8'h0C, 32'h22);
    send(9'h044, 1'b0, 1'b1, 8'h04, 1'b0);
    rdchk(8'h04, 32'h92);
    chk(32'(RX_CHAR_FLAG), 32'h0);
    apb(1'b1, 8'h04, 32'h80);
    rdchk(8'h04, 32'h80);
    apb(1'b1, 8'h18, 32'h01);
    apb(1'b1, 8'h04, 32'hD8);
    send(9'h0AA, 1'b1, 1'b1, 8'h04, 1'b0);
    chk(32'(RX_CHAR_FLAG), 32'h0);
    send(9'h1B7, 1'b1, 1'b1, 8'h04, 1'b0);
    chk(32'(RX_INT_REQ), 32'h1);
    rdchk(8'h04, 32'hD9);
    rdchk(8'h0C, 32'hB7);
    // own address matched, so software drops address mode
    apb(1'b1, 8'h04, 32'hD0);
    send(9'h05A, 1'b1, 1'b1, 8'h04, 1'b0);
    rdchk(8'h0C, 32'h5A);
    // synchronous master with single receive; the done pulse clears single receive
    apb(1'b1, 8'h00, 32'hD0);
    apb(1'b1, 8'h04, 32'hA0);
    apb(1'b1, 8'h08, 32'h19);
    chk(32'(SYNC_MODE), 32'h1);
    chk(32'(CLK_SRC_MASTER), 32'h1);
    chk(32'(TX_NINE_BIT), 32'h1);
    chk(32'(CLK_POLARITY), 32'h1);
    chk(32'(AUTOBAUD_START), 32'h0);
    chk(32'(SINGLE_RX_ENABLE), 32'h1);
    chk(32'(BAUD_TICK), 32'h1);
    SYNC_RX_DONE <= 1'b1;
    @(posedge CORE_CLK);
    SYNC_RX_DONE <= 1'b0;
    rdchk(8'h04, 32'h80);
    finish_test();
  end
endmodule
`default_nettype wire
